// ===== verilog/scrw_pkg.sv
package scrw_pkg;
    // Configuration indices of the three registers.
    localparam logic [7:0] LOCK_INDEX = 8'h41;
    localparam logic [7:0] ROMSEL_LO_INDEX = 8'h42;
    localparam logic [7:0] ROMSEL_HI_INDEX = 8'h43;
    localparam logic [7:0] WDT_B0_INDEX = 8'h44;
    localparam logic [7:0] WDT_B1_INDEX = 8'h45;
    localparam logic [7:0] WDT_B2_INDEX = 8'h46;
    // Reset values.
    localparam logic [7:0] LOCK_RESET = 8'h00;
    localparam logic [15:0] ROMSEL_RESET = 16'h0000;
    localparam logic [23:0] WDT_RESET = 24'h000002;
    // Write lock register fields.
    localparam int LOCK_UNLOCK_BIT = 0;
    localparam int LOCK_P92_SEL_BIT = 1;
    localparam int LOCK_P92_WE_BIT = 2;
    localparam int LOCK_DMA_CLK_BIT = 3;
    localparam int LOCK_BUS_RST_BIT = 4;
    localparam logic [7:0] LOCK_WRITE_MASK = 8'h1F;
    // Boot ROM select fields.
    localparam int ROM_WRITE_PERMIT_BIT = 15;
    localparam int ROM_REGION_COUNT = 11;
    localparam logic [15:0] ROMSEL_WRITE_MASK = 16'h87FF;
    // Watchdog control fields.
    localparam int WDT_ENABLE_BIT = 23;
    localparam int WDT_ACTION_HI = 22;
    localparam int WDT_ACTION_LO = 21;
    localparam int WDT_RESET_FLAG_BIT = 20;
    localparam int WDT_NMI_FLAG_BIT = 19;
    localparam int WDT_IRQ_FLAG_BIT = 18;
    // Low bits hold the timeout period fields, kept as plain storage here.
    localparam logic [23:0] WDT_PLAIN_MASK = 24'hE3FFFF;
    // Timeout actions.
    localparam logic [1:0] ACTION_RESET = 2'h0;
    localparam logic [1:0] ACTION_NMI = 2'h1;
    localparam logic [1:0] ACTION_IRQ = 2'h2;
    // DMA clock rates.
    localparam int SYS_CLOCK_HZ = 50000000;
    localparam int DMA_SLOW_HZ = 4000000;
    localparam int DMA_FAST_HZ = 8000000;
    localparam int DMA_SLOW_DIV = SYS_CLOCK_HZ / DMA_SLOW_HZ;
    localparam int DMA_FAST_DIV = SYS_CLOCK_HZ / DMA_FAST_HZ;
    // Decode windows, upper address bits compared against a base.
    localparam logic [31:0] R11_BASE = 32'hFFC00000;
    localparam logic [31:0] R10_BASE = 32'hFFD00000;
    localparam logic [31:0] R9_BASE = 32'hFFE00000;
    localparam logic [31:0] R8_BASE = 32'hFFE80000;
    localparam logic [31:0] R7_BASE = 32'hFFF00000;
    localparam logic [31:0] R6_BASE = 32'hFFF40000;
    localparam logic [31:0] R5_BASE = 32'hFFF80000;
    localparam logic [31:0] R4_BASE = 32'hFFFA0000;
    localparam logic [31:0] R3_BASE = 32'hFFFC0000;
    localparam logic [31:0] R2_BASE = 32'h000C0000;
    localparam logic [31:0] BIOS_LOW_SMALL = 32'h000F0000;
    localparam logic [31:0] BIOS_HIGH_SMALL = 32'hFFFF0000;
    localparam logic [31:0] BIOS_LOW_LARGE = 32'h000E0000;
    localparam logic [31:0] BIOS_HIGH_LARGE = 32'hFFFE0000;
    localparam logic [31:0] MASK_1M = 32'hFFF00000;
    localparam logic [31:0] MASK_512K = 32'hFFF80000;
    localparam logic [31:0] MASK_256K = 32'hFFFC0000;
    localparam logic [31:0] MASK_128K = 32'hFFFE0000;
    localparam logic [31:0] MASK_64K = 32'hFFFF0000;
endpackage : scrw_pkg

// ===== verilog/scrw_window.sv
`timescale 1ns/1ns
module scrw_window #(
    parameter logic [31:0] BASE = 32'h00000000,
    parameter logic [31:0] MASK = 32'hFFFFFFFF
) (
    // Address and gate.
    input wire logic [31:0] addr,
    input wire logic enable,
    // Match.
    output logic hit
);
    assign hit = enable && ((addr & MASK) == BASE);
endmodule : scrw_window

// ===== verilog/scrw_config.sv
`timescale 1ns/1ns
// Contract
// - Soft reset drives bus reset when enabled.
// - DMA clock select picks 4 or 8 MHz.
// - Port 92h route: 0 LPC, 1 internal.
// - Internal port 92h write enable gating.
// - Unlock bit makes identity registers writable.
// - Write permit allows chip-select on writes.
// - Bits 10, 9 enable 1 MB windows.
// - Bits 8, 7 enable 512 KB windows.
// - Bits 6, 5 enable 256 KB windows.
// - Bits 4, 3 enable 128 KB windows.
// - Bit 2 high window, bit 1 legacy window.
// - Base BIOS always decoded, bit 0 sizes.
// - Watchdog enable, off after reset.
// - Action 00 timeout issues CPU reset.
// - Action 01 NMI unless NMI flag set.
// - Action 10 IRQ unless IRQ flag set.
// - Reset flag set on watchdog reset, W1C.
// - NMI flag set on NMI event, W1C.
// - IRQ flag set on IRQ event, W1C.
// - Revision register writable only when unlocked.
module scrw_config (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Configuration cycle port, byte wide at an index.
    input wire logic cfg_write,
    input wire logic cfg_read,
    input wire logic [7:0] cfg_index,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Identity register write attempts, from the header logic.
    input wire logic id_write_request,
    output logic id_write_allowed,
    // Port 92h access.
    input wire logic p92_access,
    input wire logic p92_write,
    output logic p92_to_internal,
    output logic p92_to_lpc,
    output logic p92_internal_write,
    // Memory cycle for the boot ROM.
    input wire logic mem_cycle,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    output logic boot_rom_select_n,
    // CPU soft reset and bus reset.
    input wire logic cpu_soft_reset,
    output logic bus_reset_out_n,
    // DMA clock enable.
    output logic dma_clock_enable,
    // Watchdog timeout from the counter, and its effects.
    input wire logic watchdog_timeout,
    output logic watchdog_running,
    output logic watchdog_cpu_reset,
    output logic watchdog_nmi,
    output logic watchdog_irq
);
    logic [7:0] write_lock_lpc_control;
    logic [15:0] boot_rom_select_control;
    logic [23:0] watchdog_control;
    logic [7:0] dma_count;
    logic [7:0] next_rdata;
    logic [10:0] region_hit;
    logic bios_low_hit;
    logic bios_high_hit;
    logic any_hit;
    logic [23:0] wdt_wr_data;
    logic [23:0] wdt_wr_mask;
    logic fire_reset;
    logic fire_nmi;
    logic fire_irq;
    logic [1:0] action;

    assign action = watchdog_control[scrw_pkg::WDT_ACTION_HI:scrw_pkg::WDT_ACTION_LO];

    // Write lock register; upper bits are reserved and stay zero.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            write_lock_lpc_control <= scrw_pkg::LOCK_RESET;
        end else if (cfg_write && cfg_index == scrw_pkg::LOCK_INDEX) begin
            write_lock_lpc_control <= cfg_wdata & scrw_pkg::LOCK_WRITE_MASK;
        end
    end

    // Boot ROM select control, two bytes.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            boot_rom_select_control <= scrw_pkg::ROMSEL_RESET;
        end else if (cfg_write && cfg_index == scrw_pkg::ROMSEL_LO_INDEX) begin
            boot_rom_select_control[7:0] <= cfg_wdata & scrw_pkg::ROMSEL_WRITE_MASK[7:0];
        end else if (cfg_write && cfg_index == scrw_pkg::ROMSEL_HI_INDEX) begin
            boot_rom_select_control[15:8] <= cfg_wdata & scrw_pkg::ROMSEL_WRITE_MASK[15:8];
        end
    end

    // Watchdog byte write expanded into a word with a lane mask.
    always_comb begin
        wdt_wr_data = {cfg_wdata, cfg_wdata, cfg_wdata};
        wdt_wr_mask = 24'h000000;
        if (cfg_write) begin
            case (cfg_index)
                scrw_pkg::WDT_B0_INDEX: begin
                    wdt_wr_mask = 24'h0000FF;
                end
                scrw_pkg::WDT_B1_INDEX: begin
                    wdt_wr_mask = 24'h00FF00;
                end
                scrw_pkg::WDT_B2_INDEX: begin
                    wdt_wr_mask = 24'hFF0000;
                end
                default: begin
                    wdt_wr_mask = 24'h000000;
                end
            endcase
        end
    end

    // Timeout decision; a flag left set from an earlier event escalates to a reset.
    always_comb begin
        fire_reset = 1'b0;
        fire_nmi = 1'b0;
        fire_irq = 1'b0;
        if (watchdog_timeout && watchdog_control[scrw_pkg::WDT_ENABLE_BIT]) begin
            case (action)
                scrw_pkg::ACTION_RESET: begin
                    fire_reset = 1'b1;
                end
                scrw_pkg::ACTION_NMI: begin
                    fire_nmi = !watchdog_control[scrw_pkg::WDT_NMI_FLAG_BIT];
                    fire_reset = watchdog_control[scrw_pkg::WDT_NMI_FLAG_BIT];
                end
                scrw_pkg::ACTION_IRQ: begin
                    fire_irq = !watchdog_control[scrw_pkg::WDT_IRQ_FLAG_BIT];
                    fire_reset = watchdog_control[scrw_pkg::WDT_IRQ_FLAG_BIT];
                end
                default: begin
                    // The reserved code takes no action rather than guess one.
                    fire_reset = 1'b0;
                end
            endcase
        end
    end

    // Plain watchdog fields.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            watchdog_control[23:21] <= scrw_pkg::WDT_RESET[23:21];
            watchdog_control[17:0] <= scrw_pkg::WDT_RESET[17:0];
        end else begin
            watchdog_control[23:21] <= (watchdog_control[23:21] & ~wdt_wr_mask[23:21])
                | (wdt_wr_data[23:21] & wdt_wr_mask[23:21]);
            watchdog_control[17:0] <= (watchdog_control[17:0] & ~wdt_wr_mask[17:0])
                | (wdt_wr_data[17:0] & wdt_wr_mask[17:0]);
        end
    end

    // Event flags: a set in the same cycle as a clear wins.
    // A timeout in the write cycle must not be lost to a clear.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            watchdog_control[20:18] <= scrw_pkg::WDT_RESET[20:18];
        end else begin
            if (fire_reset) begin
                watchdog_control[scrw_pkg::WDT_RESET_FLAG_BIT] <= 1'b1;
            end else if (wdt_wr_mask[scrw_pkg::WDT_RESET_FLAG_BIT]
                && wdt_wr_data[scrw_pkg::WDT_RESET_FLAG_BIT]) begin
                watchdog_control[scrw_pkg::WDT_RESET_FLAG_BIT] <= 1'b0;
            end
            if (fire_nmi) begin
                watchdog_control[scrw_pkg::WDT_NMI_FLAG_BIT] <= 1'b1;
            end else if (wdt_wr_mask[scrw_pkg::WDT_NMI_FLAG_BIT]
                && wdt_wr_data[scrw_pkg::WDT_NMI_FLAG_BIT]) begin
                watchdog_control[scrw_pkg::WDT_NMI_FLAG_BIT] <= 1'b0;
            end
            if (fire_irq) begin
                watchdog_control[scrw_pkg::WDT_IRQ_FLAG_BIT] <= 1'b1;
            end else if (wdt_wr_mask[scrw_pkg::WDT_IRQ_FLAG_BIT]
                && wdt_wr_data[scrw_pkg::WDT_IRQ_FLAG_BIT]) begin
                watchdog_control[scrw_pkg::WDT_IRQ_FLAG_BIT] <= 1'b0;
            end
        end
    end

    // Watchdog outputs, registered; the actions follow the timeout decision each cycle, running follows the enable bit.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            watchdog_cpu_reset <= 1'b0;
            watchdog_nmi <= 1'b0;
            watchdog_irq <= 1'b0;
            watchdog_running <= 1'b0;
        end else begin
            watchdog_cpu_reset <= fire_reset;
            watchdog_nmi <= fire_nmi;
            watchdog_irq <= fire_irq;
            watchdog_running <= watchdog_control[scrw_pkg::WDT_ENABLE_BIT];
        end
    end

    // Read data mux.
    always_comb begin
        next_rdata = 8'h00;
        case (cfg_index)
            scrw_pkg::LOCK_INDEX: begin
                next_rdata = write_lock_lpc_control;
            end
            scrw_pkg::ROMSEL_LO_INDEX: begin
                next_rdata = boot_rom_select_control[7:0];
            end
            scrw_pkg::ROMSEL_HI_INDEX: begin
                next_rdata = boot_rom_select_control[15:8];
            end
            scrw_pkg::WDT_B0_INDEX: begin
                next_rdata = watchdog_control[7:0];
            end
            scrw_pkg::WDT_B1_INDEX: begin
                next_rdata = watchdog_control[15:8];
            end
            scrw_pkg::WDT_B2_INDEX: begin
                next_rdata = watchdog_control[23:16];
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // Read data changes only on a read strobe, so it stands until the next read.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_read) begin
            cfg_rdata <= next_rdata;
        end
    end

    // Identity registers, revision among them, accept writes only when unlocked.
    // The grant lags the request by one cycle, so the request must stand that long.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            id_write_allowed <= 1'b0;
        end else begin
            id_write_allowed <= id_write_request
                && write_lock_lpc_control[scrw_pkg::LOCK_UNLOCK_BIT];
        end
    end

    // Port 92h routing.
    // Both routes stay low between accesses.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            p92_to_internal <= 1'b0;
            p92_to_lpc <= 1'b0;
            p92_internal_write <= 1'b0;
        end else begin
            p92_to_internal <= p92_access && write_lock_lpc_control[scrw_pkg::LOCK_P92_SEL_BIT];
            p92_to_lpc <= p92_access && !write_lock_lpc_control[scrw_pkg::LOCK_P92_SEL_BIT];
            p92_internal_write <= p92_access && p92_write
                && write_lock_lpc_control[scrw_pkg::LOCK_P92_SEL_BIT]
                && write_lock_lpc_control[scrw_pkg::LOCK_P92_WE_BIT];
        end
    end

    // Bus reset follows soft reset only when enabled.
    // Held low through system reset, so cards behind it start clean too.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bus_reset_out_n <= 1'b0;
        end else begin
            bus_reset_out_n <= !(cpu_soft_reset
                && write_lock_lpc_control[scrw_pkg::LOCK_BUS_RST_BIT]);
        end
    end

    // DMA clock enable divider; the rate select takes effect at once, in the current period.
    // Integer division leaves both rates slightly fast.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dma_count <= 8'h00;
            dma_clock_enable <= 1'b0;
        end else if ((write_lock_lpc_control[scrw_pkg::LOCK_DMA_CLK_BIT]
            && dma_count >= 8'(scrw_pkg::DMA_FAST_DIV - 1))
            || dma_count >= 8'(scrw_pkg::DMA_SLOW_DIV - 1)) begin
            dma_count <= 8'h00;
            dma_clock_enable <= 1'b1;
        end else begin
            dma_count <= dma_count + 8'h01;
            dma_clock_enable <= 1'b0;
        end
    end

    // Region decode.
    // A window with its enable low never hits, whatever the address.
    scrw_window #(.BASE(scrw_pkg::R11_BASE), .MASK(scrw_pkg::MASK_1M)) u_r11 (
        .addr(mem_addr), .enable(boot_rom_select_control[10]), .hit(region_hit[10]));
    scrw_window #(.BASE(scrw_pkg::R10_BASE), .MASK(scrw_pkg::MASK_1M)) u_r10 (
        .addr(mem_addr), .enable(boot_rom_select_control[9]), .hit(region_hit[9]));
    scrw_window #(.BASE(scrw_pkg::R9_BASE), .MASK(scrw_pkg::MASK_512K)) u_r9 (
        .addr(mem_addr), .enable(boot_rom_select_control[8]), .hit(region_hit[8]));
    scrw_window #(.BASE(scrw_pkg::R8_BASE), .MASK(scrw_pkg::MASK_512K)) u_r8 (
        .addr(mem_addr), .enable(boot_rom_select_control[7]), .hit(region_hit[7]));
    scrw_window #(.BASE(scrw_pkg::R7_BASE), .MASK(scrw_pkg::MASK_256K)) u_r7 (
        .addr(mem_addr), .enable(boot_rom_select_control[6]), .hit(region_hit[6]));
    scrw_window #(.BASE(scrw_pkg::R6_BASE), .MASK(scrw_pkg::MASK_256K)) u_r6 (
        .addr(mem_addr), .enable(boot_rom_select_control[5]), .hit(region_hit[5]));
    scrw_window #(.BASE(scrw_pkg::R5_BASE), .MASK(scrw_pkg::MASK_128K)) u_r5 (
        .addr(mem_addr), .enable(boot_rom_select_control[4]), .hit(region_hit[4]));
    scrw_window #(.BASE(scrw_pkg::R4_BASE), .MASK(scrw_pkg::MASK_128K)) u_r4 (
        .addr(mem_addr), .enable(boot_rom_select_control[3]), .hit(region_hit[3]));
    scrw_window #(.BASE(scrw_pkg::R3_BASE), .MASK(scrw_pkg::MASK_128K)) u_r3 (
        .addr(mem_addr), .enable(boot_rom_select_control[2]), .hit(region_hit[2]));
    scrw_window #(.BASE(scrw_pkg::R2_BASE), .MASK(scrw_pkg::MASK_128K)) u_r2 (
        .addr(mem_addr), .enable(boot_rom_select_control[1]), .hit(region_hit[1]));

    // Base BIOS is never disabled; bit 0 only widens it.
    always_comb begin
        if (boot_rom_select_control[0]) begin
            bios_low_hit = (mem_addr & scrw_pkg::MASK_128K) == scrw_pkg::BIOS_LOW_LARGE;
            bios_high_hit = (mem_addr & scrw_pkg::MASK_128K) == scrw_pkg::BIOS_HIGH_LARGE;
        end else begin
            bios_low_hit = (mem_addr & scrw_pkg::MASK_64K) == scrw_pkg::BIOS_LOW_SMALL;
            bios_high_hit = (mem_addr & scrw_pkg::MASK_64K) == scrw_pkg::BIOS_HIGH_SMALL;
        end
    end

    assign region_hit[0] = bios_low_hit || bios_high_hit;
    assign any_hit = |region_hit;

    // Chip-select registered; writes need the permit bit.
    // Registering costs one cycle but keeps decode glitches off the pin.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            boot_rom_select_n <= 1'b1;
        end else begin
            boot_rom_select_n <= !(mem_cycle && any_hit
                && (!mem_write || boot_rom_select_control[scrw_pkg::ROM_WRITE_PERMIT_BIT]));
        end
    end
endmodule : scrw_config

// ===== bench/scrw_rom_model.sv
`timescale 1ns/1ns
module scrw_rom_model (
    // Clock and flash select.
    input wire logic sys_clk,
    input wire logic boot_rom_select_n,
    input wire logic mem_write,
    // Programming strobes seen by the flash.
    output int write_count
);
    int count = 0;
    logic write_seen = 1'b0;
    logic prev_program = 1'b0;
    logic program_now;
    // The select is registered, so it pairs with the write qualifier one cycle older.
    assign program_now = !boot_rom_select_n && write_seen;
    assign write_count = count;
    // One programming access is counted however many cycles its select stands.
    always @(posedge sys_clk) begin
        write_seen <= mem_write;
        prev_program <= program_now;
        if (program_now === 1'b1 && prev_program !== 1'b1) begin
            count <= count + 1;
        end
    end
endmodule : scrw_rom_model

// ===== bench/scrw_checker.sv
`timescale 1ns/1ns
module scrw_checker (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Decode side.
    input wire logic mem_cycle,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic boot_rom_select_n,
    input wire logic p92_access,
    input wire logic p92_to_internal,
    input wire logic p92_to_lpc,
    input wire logic p92_internal_write,
    input wire logic id_write_request,
    input wire logic id_write_allowed,
    // Resets, DMA clock and watchdog.
    input wire logic cpu_soft_reset,
    input wire logic bus_reset_out_n,
    input wire logic dma_clock_enable,
    input wire logic watchdog_timeout,
    input wire logic watchdog_cpu_reset,
    input wire logic watchdog_nmi,
    input wire logic watchdog_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_BUS_RST_IDLE: assert property (!cpu_soft_reset |=> bus_reset_out_n)
        else $error("bus reset without soft reset");
    AST_DMA_PULSE: assert property (dma_clock_enable |=> !dma_clock_enable)
        else $error("dma enable wider than one cycle");
    AST_P92_ROUTE: assert property (p92_access |=> p92_to_internal != p92_to_lpc)
        else $error("port route not exclusive");
    AST_P92_WRITE: assert property (p92_internal_write |-> p92_to_internal)
        else $error("internal write while routed away");
    AST_ID_CAUSE: assert property (!id_write_request |=> !id_write_allowed)
        else $error("identity write allowed without request");
    AST_ROM_IDLE: assert property (!mem_cycle |=> boot_rom_select_n)
        else $error("rom select without memory cycle");
    AST_BIOS_HIGH: assert property (mem_cycle && !mem_write && mem_addr[31:16] == 16'hFFFF
        |=> !boot_rom_select_n)
        else $error("base bios high not decoded");
    AST_BIOS_LOW: assert property (mem_cycle && !mem_write && mem_addr[31:16] == 16'h000F
        |=> !boot_rom_select_n)
        else $error("base bios low not decoded");
    AST_WDT_CAUSE: assert property ((watchdog_cpu_reset || watchdog_nmi || watchdog_irq)
        |-> $past(watchdog_timeout))
        else $error("watchdog action without timeout");
    AST_WDT_ONE: assert property ($onehot0({watchdog_cpu_reset, watchdog_nmi, watchdog_irq}))
        else $error("two watchdog actions at once");
    AST_NMI_ESCALATE: assert property (watchdog_nmi |=> !watchdog_nmi)
        else $error("second nmi without escalation");
    cover property (!boot_rom_select_n);
    cover property (watchdog_nmi);
    cover property (watchdog_irq);
    cover property (watchdog_cpu_reset);
endmodule : scrw_checker
bind scrw_config scrw_checker scrw_checker_i (.sys_clk, .reset, .mem_cycle, .mem_write, .mem_addr,
    .boot_rom_select_n, .p92_access, .p92_to_internal, .p92_to_lpc, .p92_internal_write,
    .id_write_request, .id_write_allowed, .cpu_soft_reset, .bus_reset_out_n, .dma_clock_enable,
    .watchdog_timeout, .watchdog_cpu_reset, .watchdog_nmi, .watchdog_irq);

// ===== bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic sys_clk, reset, cfg_write, cfg_read, id_write_request, p92_access, p92_write;
    logic mem_cycle, mem_write, cpu_soft_reset, watchdog_timeout;
    logic [7:0] cfg_index, cfg_wdata, cfg_rdata;
    logic [31:0] mem_addr;
    logic id_write_allowed, p92_to_internal, p92_to_lpc, p92_internal_write, boot_rom_select_n;
    logic bus_reset_out_n, dma_clock_enable, watchdog_running, watchdog_cpu_reset, watchdog_nmi, watchdog_irq;
    int fails, n_checks, write_count;
    localparam logic [31:0] LO [10] = '{32'h000C0000, 32'hFFFC0000, 32'hFFFA0000, 32'hFFF80000,
        32'hFFF40000, 32'hFFF00000, 32'hFFE80000, 32'hFFE00000, 32'hFFD00000, 32'hFFC00000};
    localparam logic [31:0] HI [10] = '{32'h000DFFFF, 32'hFFFDFFFF, 32'hFFFBFFFF, 32'hFFF9FFFF,
        32'hFFF7FFFF, 32'hFFF3FFFF, 32'hFFEFFFFF, 32'hFFE7FFFF, 32'hFFDFFFFF, 32'hFFCFFFFF};
    scrw_config scrw_config_i (.sys_clk, .reset, .cfg_write, .cfg_read, .cfg_index, .cfg_wdata,
        .cfg_rdata, .id_write_request, .id_write_allowed, .p92_access, .p92_write, .p92_to_internal,
        .p92_to_lpc, .p92_internal_write, .mem_cycle, .mem_write, .mem_addr, .boot_rom_select_n,
        .cpu_soft_reset, .bus_reset_out_n, .dma_clock_enable, .watchdog_timeout, .watchdog_running,
        .watchdog_cpu_reset, .watchdog_nmi, .watchdog_irq);
    scrw_rom_model scrw_rom_model_i (.sys_clk, .boot_rom_select_n, .mem_write, .write_count);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge sys_clk);
        cfg_write <= 1'b1;
        cfg_index <= idx;
        cfg_wdata <= d;
        @(posedge sys_clk);
        cfg_write <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        @(posedge sys_clk);
        cfg_read <= 1'b1;
        cfg_index <= idx;
        @(posedge sys_clk);
        cfg_read <= 1'b0;
        #1;
        chk(cfg_rdata, exp);
    endtask : rdc
    task automatic probe(input logic [31:0] a, input logic w, input logic sel);
        @(posedge sys_clk);
        mem_cycle <= 1'b1;
        mem_write <= w;
        mem_addr <= a;
        @(posedge sys_clk);
        #1;
        chk(boot_rom_select_n, !sel);
    endtask : probe
    task automatic tmo(input logic [2:0] e);
        @(posedge sys_clk);
        watchdog_timeout <= 1'b1;
        @(posedge sys_clk);
        watchdog_timeout <= 1'b0;
        #1;
        chk({watchdog_cpu_reset, watchdog_nmi, watchdog_irq}, e);
    endtask : tmo
    // Skips one pulse first, since a rate change may leave a short first period.
    task automatic dma_gap(input int e);
        int n;
        for (n = 0; n < 30 && dma_clock_enable !== 1'b1; n++) @(posedge sys_clk) #1;
        n = 0;
        do begin
            @(posedge sys_clk) #1;
            n++;
        end while (dma_clock_enable !== 1'b1 && n < 30);
        chk(n, e);
    endtask : dma_gap
    task automatic t_reset;
        rdc(8'h41, 8'h00);
        rdc(8'h42, 8'h00);
        rdc(8'h43, 8'h00);
        rdc(8'h44, 8'h02);
        rdc(8'h45, 8'h00);
        rdc(8'h46, 8'h00);
        rdc(8'h47, 8'h00);
        chk(watchdog_running, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_lock;
        wr(8'h41, 8'hFF);
        rdc(8'h41, 8'h1F);
        @(posedge sys_clk);
        id_write_request <= 1'b1;
        p92_access <= 1'b1;
        p92_write <= 1'b1;
        cpu_soft_reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(id_write_allowed, 1'b1);
        chk({p92_to_internal, p92_to_lpc, p92_internal_write}, 3'b101);
        chk(bus_reset_out_n, 1'b0);
        dma_gap(scrw_pkg::DMA_FAST_DIV);
        wr(8'h41, 8'h02);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(id_write_allowed, 1'b0);
        chk({p92_to_internal, p92_to_lpc, p92_internal_write}, 3'b100);
        chk(bus_reset_out_n, 1'b1);
        wr(8'h41, 8'h04);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({p92_to_internal, p92_to_lpc, p92_internal_write}, 3'b010);
        dma_gap(scrw_pkg::DMA_SLOW_DIV);
        @(posedge sys_clk);
        id_write_request <= 1'b0;
        p92_access <= 1'b0;
        cpu_soft_reset <= 1'b0;
        $display("test lock and routing done");
    endtask : t_lock
    task automatic t_rom;
        logic [15:0] en;
        for (int i = 0; i < 10; i++) begin
            en = 16'h0002 << i;
            wr(8'h42, en[7:0]);
            wr(8'h43, en[15:8]);
            for (int j = 0; j < 10; j++) begin
                probe(LO[j], 1'b0, i == j);
                probe(HI[j], 1'b0, i == j);
            end
        end
        wr(8'h42, 8'h00);
        wr(8'h43, 8'h00);
        probe(32'hFFFF0000, 1'b0, 1'b1);
        probe(32'hFFFE0000, 1'b0, 1'b0);
        probe(32'h000E0000, 1'b0, 1'b0);
        probe(32'hFFFF0000, 1'b1, 1'b0);
        wr(8'h42, 8'h01);
        probe(32'hFFFE0000, 1'b0, 1'b1);
        probe(32'h000E0000, 1'b0, 1'b1);
        wr(8'h43, 8'h80);
        probe(32'h000FFFFF, 1'b1, 1'b1);
        probe(32'h000F0000, 1'b0, 1'b1);
        chk(write_count, 1);
        @(posedge sys_clk);
        mem_cycle <= 1'b0;
        $display("test rom decode done");
    endtask : t_rom
    task automatic t_wdt;
        wr(8'h46, 8'h80);
        tmo(3'b100);
        rdc(8'h46, 8'h90);
        chk(watchdog_running, 1'b1);
        wr(8'h46, 8'hB0);
        rdc(8'h46, 8'hA0);
        tmo(3'b010);
        rdc(8'h46, 8'hA8);
        tmo(3'b100);
        rdc(8'h46, 8'hB8);
        wr(8'h46, 8'hD8);
        rdc(8'h46, 8'hC0);
        tmo(3'b001);
        rdc(8'h46, 8'hC4);
        tmo(3'b100);
        wr(8'h46, 8'hE0);
        tmo(3'b000);
        rdc(8'h46, 8'hF4);
        wr(8'h46, 8'h14);
        rdc(8'h46, 8'h00);
        tmo(3'b000);
        chk(watchdog_running, 1'b0);
        $display("test watchdog done");
    endtask : t_wdt
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        fails = 0;
        n_checks = 0;
        reset = 1'b1;
        {cfg_write, cfg_read, id_write_request, p92_access, p92_write} = '0;
        {mem_cycle, mem_write, cpu_soft_reset, watchdog_timeout} = '0;
        cfg_index = 8'h00;
        cfg_wdata = 8'h00;
        mem_addr = 32'h00000000;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset;
        t_lock;
        t_rom;
        t_wdt;
        wrap_up;
    end
    // The tests need under two thousand cycles, so this leaves a wide margin.
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        wrap_up;
    end
endmodule : tb_top
